/* File: rtl/sfec_core.sv */
// Purpose: erase and write gating of a serial flash behind its spi pins
// Assumes: host keeps sck still while select is high; mode 0 link
// Notes:   the array itself sits outside and follows the erase port
`timescale 1ns/1ps
module sfec_core #(
   parameter longint CHIP_CYC = sfec_pkg::CHIP_ERASE_CYC,  // chip erase length
   parameter longint SECT_CYC = sfec_pkg::SECTOR_ERASE_CYC // sector erase length
) (
   input  wire logic       i_clock,              // core clock
   input  wire logic       i_srst,               // sync reset, high
   input  wire logic       i_sck,                // spi clock, link domain
   input  wire logic       i_cs_n,               // chip select, low active
   input  wire logic       i_si,                 // serial data in
   input  wire logic       i_lock_level_low_bit, // lock level bit 0
   input  wire logic       i_lock_level_high_bit,// lock level bit 1
   output logic            o_so,                 // serial data out
   output logic            o_so_oe,              // so driven
   output logic            o_busy,               // internal cycle runs
   output logic            o_write_enabled,      // enable latch
   output logic            o_erase_active,       // array being erased
   output logic [3:0]      o_erase_sectors,      // sectors being erased
   output logic [7:0]      o_fill_byte,          // value of erased bytes
   output logic            o_erase_done          // one cycle at end
);
   //---------------------------------------------------------------
   // helpers
   //---------------------------------------------------------------
   // one-hot sector from address, offset bits ignored
   function automatic logic [3:0] sect_of(input logic [23:0] a);
      logic [1:0] s;
      s = a[sfec_pkg::SECT_MSB:sfec_pkg::SECT_LSB]; // R3 R6 R8
      sect_of = 4'h1 << s;
   endfunction
   // sectors locked by the lock level
   function automatic logic [3:0] locked(input logic hi, input logic lo);
      case ({hi, lo}) // R18
         2'b00:   locked = 4'h0;
         2'b01:   locked = 4'h8;
         2'b10:   locked = 4'hC;
         default: locked = 4'hF;
      endcase
   endfunction

   //---------------------------------------------------------------
   // link domain: shift in opcode and address
   //---------------------------------------------------------------
   logic        start_q;                // set while select high
   logic [5:0]  bitcnt_q, bitcnt_d;     // bits this frame, saturating
   logic [7:0]  opcode_q, opcode_d;     // first byte
   logic [23:0] addr_q, addr_d;         // address field
   logic [2:0]  phase_q, phase_d;       // bit within status byte
   logic [7:0]  shreg_q, shreg_d;       // status shift register
   logic [7:0]  stat_s1_q, stat_s2_q;   // status synchroniser
   logic        so_q, so_oe_q;          // falling edge outputs
   logic [7:0]  status_q;               // core status byte

   // select high arms a fresh frame, so a dropped one ends here
   always_ff @(posedge i_sck or posedge i_cs_n) begin
      if (i_cs_n) begin
         start_q <= 1'b1; // R2
      end else begin
         start_q <= 1'b0;
      end
   end

   // next values of the shifter
   always_comb begin
      bitcnt_d = start_q ? 6'h01 :
                 (bitcnt_q == sfec_pkg::BITCNT_MAX) ? bitcnt_q : bitcnt_q + 6'h01;
      opcode_d = opcode_q;
      addr_d   = addr_q;
      if (bitcnt_d <= sfec_pkg::OPCODE_BITS) begin
         opcode_d = {(start_q ? 7'h00 : opcode_q[6:0]), i_si};
      end else if (bitcnt_d <= sfec_pkg::ERASE_BITS) begin
         addr_d = {addr_q[22:0], i_si};
      end
      phase_d = start_q ? 3'h1 : phase_q + 3'h1;
      if (phase_d == 3'h0) begin
         shreg_d = stat_s2_q; // reload every 8 bits
      end else begin
         shreg_d = {shreg_q[6:0], 1'b0};
      end
   end

   // shifter registers, quiet while select is high
   always_ff @(posedge i_sck) begin
      bitcnt_q  <= bitcnt_d;
      opcode_q  <= opcode_d;
      addr_q    <= addr_d;
      phase_q   <= phase_d;
      shreg_q   <= shreg_d;
      stat_s1_q <= status_q;
      stat_s2_q <= stat_s1_q;
   end

   // status read output on falling edges; served even when busy
   always_ff @(negedge i_sck or posedge i_cs_n) begin
      if (i_cs_n) begin
         so_q    <= 1'b0;
         so_oe_q <= 1'b0;
      end else begin
         so_q    <= shreg_q[7];
         so_oe_q <= (opcode_q == sfec_pkg::STATUS_READ_CMD) &&
                    (bitcnt_q >= sfec_pkg::OPCODE_BITS); // R9 R14
      end
   end
   assign o_so    = so_q;
   assign o_so_oe = so_oe_q;

   //---------------------------------------------------------------
   // core domain: select synchroniser and command decode
   //---------------------------------------------------------------
   logic              cs_s1_q, cs_s2_q, cs_s3_q; // sync and edge
   logic              cs_rise;                   // frame closed
   sfec_pkg::sfec_state_t state_q, state_d;      // erase state
   logic [31:0]       timer_q, timer_d;          // cycles left
   logic              wen_q, wen_d;              // enable latch
   logic [3:0]        sect_q, sect_d;            // sectors erased
   logic              done_q, done_d;            // end pulse
   logic [3:0]        lock_v;                    // locked sectors
   logic [3:0]        tgt;                       // wanted sectors
   logic              is_erase;                  // erase frame
   logic              len_ok;                    // exactly 32 bits
   sfec_pkg::sfec_status_t st_d;                 // status fields

   // select crossing; cs_s2_q and cs_s3_q make the edge
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
      end else begin
         cs_s1_q <= i_cs_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
      end
   end
   assign cs_rise = cs_s2_q & ~cs_s3_q;

   // frame words are stable once select is high and sck still
   always_comb begin
      lock_v   = locked(i_lock_level_high_bit, i_lock_level_low_bit);
      is_erase = (opcode_q == sfec_pkg::SECTOR_ERASE_CMD) ||
                 (opcode_q == sfec_pkg::CHIP_ERASE_CMD);
      len_ok   = (bitcnt_q == sfec_pkg::ERASE_BITS); // R19
      tgt      = (opcode_q == sfec_pkg::CHIP_ERASE_CMD) ? 4'hF : sect_of(addr_q); // R11
      state_d  = state_q;
      timer_d  = timer_q;
      wen_d    = wen_q;
      sect_d   = sect_q;
      done_d   = 1'b0;
      case (state_q)
         sfec_pkg::SFEC_IDLE: begin
            if (cs_rise) begin
               if ((opcode_q == sfec_pkg::SET_WRITE_LATCH_CMD) &&
                   (bitcnt_q == sfec_pkg::OPCODE_BITS)) begin
                  wen_d = 1'b1; // R17
               end else if ((opcode_q == sfec_pkg::CLR_WRITE_LATCH_CMD) &&
                            (bitcnt_q == sfec_pkg::OPCODE_BITS)) begin
                  wen_d = 1'b0;
               end else if (is_erase && wen_q && len_ok &&
                            ((tgt & ~lock_v) != 4'h0)) begin // R1 R5 R12
                  sect_d = tgt & ~lock_v; // R7 R11
                  if (opcode_q == sfec_pkg::CHIP_ERASE_CMD) begin
                     state_d = sfec_pkg::SFEC_CHIP;
                     timer_d = 32'(CHIP_CYC); // R13
                  end else begin
                     state_d = sfec_pkg::SFEC_SECT;
                     timer_d = 32'(SECT_CYC);
                  end
               end
            end
         end
         sfec_pkg::SFEC_SECT, sfec_pkg::SFEC_CHIP: begin
            // frames other than status read are ignored here
            if (timer_q <= 32'h1) begin // R9 R14
               state_d = sfec_pkg::SFEC_IDLE;
               timer_d = 32'h0;
               wen_d   = 1'b0; // R10 R15
               sect_d  = 4'h0;
               done_d  = 1'b1;
            end else begin
               timer_d = timer_q - 32'h1;
            end
         end
         default: begin
            state_d = sfec_pkg::SFEC_IDLE;
            timer_d = 32'h0;
            sect_d  = 4'h0;
         end
      endcase
      st_d.protect_en = 1'b0;
      st_d.spare      = 3'h0;
      st_d.lock_hi    = i_lock_level_high_bit;
      st_d.lock_lo    = i_lock_level_low_bit;
      st_d.wen        = wen_d; // R17
      st_d.busy       = (state_d != sfec_pkg::SFEC_IDLE); // R16
   end

   // core registers
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state_q         <= sfec_pkg::SFEC_IDLE;
         timer_q         <= 32'h0;
         wen_q           <= 1'b0;
         sect_q          <= 4'h0;
         done_q          <= 1'b0;
         status_q        <= 8'h00;
         o_busy          <= 1'b0;
         o_write_enabled <= 1'b0;
         o_erase_active  <= 1'b0;
         o_erase_sectors <= 4'h0;
         o_fill_byte     <= sfec_pkg::ERASED_BYTE;
         o_erase_done    <= 1'b0;
      end else begin
         state_q         <= state_d;
         timer_q         <= timer_d;
         wen_q           <= wen_d;
         sect_q          <= sect_d;
         done_q          <= done_d;
         status_q        <= st_d.busy ? sfec_pkg::BUSY_STATUS : st_d; // R16
         o_busy          <= st_d.busy;
         o_write_enabled <= wen_d;
         o_erase_active  <= st_d.busy;
         o_erase_sectors <= sect_d;
         o_fill_byte     <= sfec_pkg::ERASED_BYTE; // R20
         o_erase_done    <= done_d;
      end
   end

   //---------------------------------------------------------------
   // checks
   //---------------------------------------------------------------
   sequence frame_close_s;
      cs_rise && (state_q == sfec_pkg::SFEC_IDLE);
   endsequence
   sequence erase_start_s;
      (state_q == sfec_pkg::SFEC_IDLE) && (state_d != sfec_pkg::SFEC_IDLE);
   endsequence

   no_wen_drop_a: assert property (@(posedge i_clock) disable iff (i_srst) // R1
      (frame_close_s and (is_erase && !wen_q)) |=> (!o_busy) [*2])
      else $error("erase ran without enable latch");
   exact_len_a: assert property (@(posedge i_clock) disable iff (i_srst) // R19
      erase_start_s |-> (bitcnt_q == 6'h20) && wen_q && cs_rise)
      else $error("erase started on a bad frame");
   sect_pick_a: assert property (@(posedge i_clock) disable iff (i_srst) // R8
      (erase_start_s and (opcode_q == sfec_pkg::SECTOR_ERASE_CMD))
      |=> o_erase_sectors == (4'h1 << $past(addr_q[16:15])))
      else $error("wrong sector chosen");
   lock_keep_a: assert property (@(posedge i_clock) disable iff (i_srst) // R7
      o_erase_active |-> ((o_erase_sectors & lock_v) == 4'h0))
      else $error("locked sector erased");
   chip_all_a: assert property (@(posedge i_clock) disable iff (i_srst) // R11
      (erase_start_s and (opcode_q == sfec_pkg::CHIP_ERASE_CMD))
      |=> o_erase_sectors == ~$past(lock_v))
      else $error("chip erase missed a sector");
   busy_ignore_a: assert property (@(posedge i_clock) disable iff (i_srst) // R9
      (cs_rise && (state_q != sfec_pkg::SFEC_IDLE) && (timer_q > 32'h1))
      |=> $stable(o_erase_sectors) && o_busy && $stable(state_q))
      else $error("command taken while busy");
   wen_clear_a: assert property (@(posedge i_clock) disable iff (i_srst) // R10
      $rose(o_erase_done) |-> !o_write_enabled && !o_busy ##1 !o_erase_done)
      else $error("enable latch kept after erase");
   wen_set_a: assert property (@(posedge i_clock) disable iff (i_srst) // R17
      (frame_close_s and (opcode_q == sfec_pkg::SET_WRITE_LATCH_CMD) &&
       (bitcnt_q == 6'h08)) |=> o_write_enabled ##1 status_q[1])
      else $error("enable latch not set");
   busy_flag_a: assert property (@(posedge i_clock) disable iff (i_srst) // R16
      o_busy |-> (status_q == 8'hFF) && (state_q != sfec_pkg::SFEC_IDLE))
      else $error("busy status wrong");
   fill_ff_a: assert property (@(posedge i_clock) disable iff (i_srst) // R20
      ##1 o_fill_byte == 8'hFF)
      else $error("erased byte value wrong");
endmodule : sfec_core

/* File: pkg/sfec_pkg.sv */
// Purpose: constants and types of the serial flash erase control block
// Assumes: core clock 250 MHz, spi mode 0 on the link
// Notes:   opcode values and the sector erase time are plain defaults
//
// How it works
// R1 - write-type command without enable is dropped
// R2 - new select fall needed before next command
// R3 - only address bits 16..0 are used
// R4 - host erases sector before reprogramming a byte
// R5 - sector erase needs enable latch set first
// R6 - four 32 KB sectors by address bits 16..15
// R7 - sector erase clears sector unless locked
// R8 - any address inside picks its sector
// R9 - sector erase self-timed, only status read served
// R10 - enable latch clears after sector erase
// R11 - chip erase clears all unlocked sectors
// R12 - chip erase needs enable latch set first
// R13 - chip erase lasts 3.5 seconds
// R14 - chip erase busy serves only status read
// R15 - enable latch clears after chip erase
// R16 - status bit 0 shows busy
// R17 - status bit 1 shows enable latch
// R18 - lock bits 00 none 01 s4 10 s3-4 11 all
// R19 - erase starts only after exactly 32 bits
// R20 - erased bytes read as FF
package sfec_pkg;
   //---------------------------------------------------------------
   // opcodes
   //---------------------------------------------------------------
   localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06; // enable latch set
   localparam logic [7:0] CLR_WRITE_LATCH_CMD = 8'h04; // enable latch clear
   localparam logic [7:0] STATUS_READ_CMD     = 8'h05; // status read
   localparam logic [7:0] SECTOR_ERASE_CMD    = 8'h52; // erase one sector
   localparam logic [7:0] CHIP_ERASE_CMD      = 8'h62; // erase whole array
   //---------------------------------------------------------------
   // frame lengths, address field, values
   //---------------------------------------------------------------
   localparam logic [5:0] OPCODE_BITS  = 6'h08;  // bits of a bare opcode
   localparam logic [5:0] ERASE_BITS   = 6'h20;  // opcode plus 24 address bits
   localparam logic [5:0] BITCNT_MAX   = 6'h3F;  // counter saturates here
   localparam int         SECT_MSB     = 16;     // top used address bit
   localparam int         SECT_LSB     = 15;     // sector select low bit
   localparam logic [7:0] ERASED_BYTE  = 8'hFF;  // erased byte value
   localparam logic [7:0] BUSY_STATUS  = 8'hFF;  // status during a cycle
   //---------------------------------------------------------------
   // timing
   //---------------------------------------------------------------
   localparam longint CLOCK_KHZ        = 250000; // core clock rate
   localparam longint CHIP_ERASE_MS    = 3500;   // chip erase time
   localparam longint SECTOR_ERASE_MS  = 1000;   // sector erase time
   localparam longint CHIP_ERASE_CYC   = CHIP_ERASE_MS * CLOCK_KHZ;
   localparam longint SECTOR_ERASE_CYC = SECTOR_ERASE_MS * CLOCK_KHZ;
   //---------------------------------------------------------------
   // types
   //---------------------------------------------------------------
   typedef enum logic [1:0] {
      SFEC_IDLE  = 2'b00, // ready for commands
      SFEC_SECT  = 2'b01, // sector erase running
      SFEC_CHIP  = 2'b10  // chip erase running
   } sfec_state_t;
   typedef struct packed {
      logic       protect_en; // not held here, reads 0 when ready
      logic [2:0] spare;      // read 0 when ready
      logic       lock_hi;    // lock level high bit
      logic       lock_lo;    // lock level low bit
      logic       wen;        // enable latch
      logic       busy;       // internal cycle running
   } sfec_status_t;
endpackage : sfec_pkg

/* File: testbench/sfec_host.sv */
// Purpose: spi host model that frames commands for the erase control block
// Assumes: mode 0, sck period 12 ns, sck still while select is high
// Notes:   si shows the inverse of its last bit once released
`timescale 1ns/1ps
module sfec_host (
   output logic      o_sck,  // spi clock, still outside frames
   output logic      o_cs_n, // chip select, low active
   output logic      o_si,   // serial data to the device
   input  wire logic i_so    // status bits back
);
   //----------------------------------------------------------------
   // idle levels
   //----------------------------------------------------------------
   // select starts low for a moment so the link side sees a clean rising edge
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b0;
      o_si = 1'b0;
      #1 o_cs_n = 1'b1;
   end
   // one frame: n bits of v msb first, then extra clocks to read back
   task automatic send(input logic [31:0] v, input int n, input int extra,
                       output logic [7:0] rd);
      o_cs_n = 1'b0;
      for (int i = 0; i < n + extra; i++) begin
         if (i < n) o_si = v[31 - i]; // changed while sck is low
         #6 o_sck = 1'b1;
         rd = {rd[6:0], i_so};         // sampled on the rising edge
         #6 o_sck = 1'b0;
      end
      #6 o_cs_n = 1'b1;
      o_si = ~o_si;                    // released line, no stale value
      #40;
   endtask
endmodule // sfec_host

/* File: testbench/sfec_core_tb.sv */
// Purpose: self-checking bench of the erase control block
// Assumes: shortened erase lengths, host model on the spi pins
// Notes:   a watcher compares each erase against the oldest note
`timescale 1ns/1ps
module sfec_core_tb;
   localparam longint SECT_N = 400; // shortened sector erase
   localparam longint CHIP_N = 600; // shortened chip erase
   typedef struct packed {
      logic [3:0]  mask; // sectors expected to clear
      logic [15:0] len;  // expected busy cycles
   } sfec_note_t;
   logic        clock = 1'b0;         // core clock
   logic        srst = 1'b1;          // sync reset
   logic [1:0]  lock = 2'b00;         // lock level bits
   logic        sck;                  // spi clock
   logic        cs_n;                 // chip select
   logic        si;                   // serial data in
   logic        so;                   // serial data out
   logic        so_oe;                // serial data out driven
   logic        act;                  // array being erased
   logic        oe_seen = 1'b0;       // so enable seen this frame
   logic        busy;                 // erase running
   logic        wen;                  // enable latch
   logic        done;                 // end pulse
   logic [3:0]  sect;                 // sectors being erased
   logic [7:0]  fill;                 // erased byte value
   logic [7:0]  rd;                   // status byte read back
   logic [31:0] rnd = 32'h4CE5466B;   // random state
   logic        prev_busy = 1'b0;     // busy one cycle ago
   int          run_n = 0;            // busy cycles so far
   int          err_count = 0;        // mismatches
   int          check_count = 0;      // comparisons
   sfec_note_t  note_q[$];            // expected erases
   sfec_note_t  nt;                   // note in progress
   always #2 clock = ~clock;
   sfec_core #(.CHIP_CYC(CHIP_N), .SECT_CYC(SECT_N)) i_sfec_core (
      .i_clock(clock), .i_srst(srst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
      .i_lock_level_low_bit(lock[0]), .i_lock_level_high_bit(lock[1]),
      .o_so(so), .o_so_oe(so_oe), .o_busy(busy), .o_write_enabled(wen),
      .o_erase_active(act), .o_erase_sectors(sect), .o_fill_byte(fill),
      .o_erase_done(done));
   sfec_host i_sfec_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so));
   // notes whether the device drove so at any rising sck of the frame
   always @(posedge sck) begin
      if (so_oe === 1'b1) begin
         oe_seen <= 1'b1;
      end
   end
   //----------------------------------------------------------------
   // helpers
   //----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %0s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n);
      oe_seen = 1'b0;
      i_sfec_host.send({op, a}, n, 0, rd);
      check(16'(oe_seen), 16'h0000, "so enable quiet");
   endtask
   // status read, second byte taken so a late busy has crossed
   task automatic status(input logic [7:0] exp);
      oe_seen = 1'b0;
      i_sfec_host.send({sfec_pkg::STATUS_READ_CMD, 24'h000000}, 8, 16, rd);
      check(16'(rd), 16'(exp), "status");
      check(16'(oe_seen), 16'h0001, "so enable");
   endtask
   // erase frame; a mask of zero means the frame must be dropped
   task automatic erase(input logic [7:0] op, input logic [23:0] a, input int n,
                        input logic [3:0] m, input longint len);
      if (m != 4'h0) note_q.push_back({m, 16'(len)});
      frame(op, a, n);
      @(negedge clock);
      if (m == 4'h0) check(16'(busy), 16'h0000, "dropped erase");
   endtask
   task automatic settle();
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 5000) begin
         @(negedge clock);
         k++;
      end
      if (k == 5000) check(16'h0001, 16'h0000, "busy stuck");
   endtask
   //----------------------------------------------------------------
   // watcher: takes the oldest note whenever an erase starts
   //----------------------------------------------------------------
   // sampled on the falling edge, where the registered outputs have settled
   always @(negedge clock) begin
      prev_busy <= busy;
      run_n <= (busy === 1'b1) ? run_n + 1 : 0;
      if (busy === 1'b1 && prev_busy === 1'b0) begin
         if (note_q.size() == 0) check(16'h0001, 16'h0000, "unexpected erase");
         else begin
            nt = note_q.pop_front();
            check(16'(sect), 16'(nt.mask), "sectors");
            check(16'(fill), 16'h00FF, "fill byte");
            check(16'(act), 16'h0001, "erase active");
         end
      end
      if (busy === 1'b0 && prev_busy === 1'b1) begin
         check(16'(run_n), nt.len, "busy length");
         check(16'(wen), 16'h0000, "latch at end");
         check(16'(done), 16'h0001, "done pulse");
      end
   end
   initial begin
      #150000;
      err_count++;
      print_verdict();
   end
   //----------------------------------------------------------------
   // tests
   //----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clock);
      @(negedge clock) srst = 1'b0;
      #40;
      @(negedge clock) lock = 2'b11;
      status(8'h0C);
      @(negedge clock) lock = 2'b00;
      erase(sfec_pkg::SECTOR_ERASE_CMD, 24'h000100, 32, 4'h0, 0);
      frame(sfec_pkg::SET_WRITE_LATCH_CMD, 24'h000000, 8);
      status(8'h02);
      erase(sfec_pkg::SECTOR_ERASE_CMD, 24'h000100, 31, 4'h0, 0);
      $display("test refusals done");
      for (int s = 0; s < 4; s++) begin
         rnd = lfsr(rnd);
         frame(sfec_pkg::SET_WRITE_LATCH_CMD, 24'h000000, 8);
         erase(sfec_pkg::SECTOR_ERASE_CMD, {rnd[23:17], 2'(s), rnd[14:0]}, 32,
               4'(1 << s), SECT_N);
         status(8'hFF);
         frame(sfec_pkg::CHIP_ERASE_CMD, rnd[23:0], 32); // ignored while busy
         settle();
      end
      $display("test sector erase done");
      for (int lv = 0; lv < 4; lv++) begin
         rnd = lfsr(rnd);
         @(negedge clock) lock = 2'(lv);
         frame(sfec_pkg::SET_WRITE_LATCH_CMD, 24'h000000, 8);
         erase(sfec_pkg::CHIP_ERASE_CMD, rnd[23:0], 32,
               (lv == 3) ? 4'h0 : (4'hF >> lv), CHIP_N);
         settle();
         check(16'(wen), (lv == 3) ? 16'h0001 : 16'h0000, "latch after chip");
      end
      frame(sfec_pkg::CLR_WRITE_LATCH_CMD, 24'h000000, 8);
      @(negedge clock);
      check(16'(wen), 16'h0000, "latch cleared");
      $display("test chip erase done");
      @(negedge clock) lock = 2'b01;
      frame(sfec_pkg::SET_WRITE_LATCH_CMD, 24'h000000, 8);
      erase(sfec_pkg::SECTOR_ERASE_CMD, 24'h018123, 32, 4'h0, 0);
      erase(sfec_pkg::SECTOR_ERASE_CMD, 24'hFF0042, 32, 4'h4, SECT_N);
      settle();
      $display("test locked sector done");
      #100;
      print_verdict();
   end
endmodule // sfec_core_tb
